// [src/csi_pkg.sv]
// Constants, field layout and state type of the clocked serial interface
package csi_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [15:0] CSI_ADDR_CTRL   = 16'hFF70;
	localparam logic [15:0] CSI_ADDR_MODE   = 16'hFF71;
	localparam logic [15:0] CSI_ADDR_DATA_L = 16'hFF72;
	localparam logic [15:0] CSI_ADDR_DATA_H = 16'hFF73;
	// ==========================================================
	// Field positions
	localparam int CSI_CTRL_PORT_SEL = 0;
	localparam int CSI_CTRL_TRIGGER  = 1;
	localparam int CSI_CTRL_OUT_EN   = 2;
	localparam int CSI_MODE_SRC_LO   = 0;
	localparam int CSI_MODE_SRC_HI   = 1;
	localparam int CSI_MODE_PHASE    = 2;
	localparam int CSI_MODE_ORDER    = 3;
	// ==========================================================
	// Reset values and counts
	localparam logic [3:0] CSI_CTRL_RESET = 4'h0;
	localparam logic [3:0] CSI_MODE_RESET = 4'h0;
	localparam logic [7:0] CSI_DATA_RESET = 8'h00;
	localparam logic [2:0] CSI_LAST_BIT   = 3'h7;
	localparam logic [4:0] CSI_EDGES_XFER = 5'h10;
	// ==========================================================
	// Clock source codes
	localparam logic [1:0] CSI_SRC_TICK_A   = 2'h0;
	localparam logic [1:0] CSI_SRC_TICK_B   = 2'h1;
	localparam logic [1:0] CSI_SRC_OSC_DIV2 = 2'h2;
	localparam logic [1:0] CSI_SRC_OSC      = 2'h3;
	// ==========================================================
	// Transfer sequencer states, Gray along idle-run-done
	typedef enum logic [1:0] {
		CSI_IDLE = 2'h0,
		CSI_RUN  = 2'h1,
		CSI_DONE = 2'h3
	} csi_state_t;
endpackage

// [src/csi_fifo.sv]
// Receive FIFO built from flip-flops, valid and ready on both sides
`timescale 1ns/1ps
module csi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0]    wrPtr_reg, wrPtr_next;
	logic [AW-1:0]    rdPtr_reg, rdPtr_next;
	logic [AW:0]      count_reg, count_next;
	logic             push;
	logic             pop;

	// ==========================================================
	// Pointer arithmetic
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// Honest full and empty
	assign inReady  = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem_reg[rdPtr_reg];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Next state of storage and pointers
	always_comb begin
		mem_next   = mem_reg;
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (push) begin
			mem_next[wrPtr_reg] = inData;
			wrPtr_next          = bump(wrPtr_reg);
		end
		if (pop) begin
			rdPtr_next = bump(rdPtr_reg);
		end
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	// Registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			mem_reg   <= mem_next;
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
	end
endmodule // csi_fifo

// [src/csi_serial.sv]
// Clocked serial interface: registers, shift engine, pin mux and receive FIFO
`timescale 1ns/1ps
module csi_serial
	import csi_pkg::*;
#(
	parameter int FIFO_DEPTH   = 8,
	parameter bit NEG_POLARITY = 1'b1
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] regAddr,
	input  wire logic [3:0]  regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [3:0]  regRdData,
	input  wire logic        lowSpeedOscTick,
	input  wire logic        timerTickA,
	input  wire logic        timerTickB,
	input  wire logic [1:0]  gpioOut,
	input  wire logic [1:0]  gpioOe,
	output logic             sclkPinOut,
	output logic             sclkPinOe,
	output logic             serialOutputPinOut,
	output logic             serialOutputPinOe,
	input  wire logic        serialInputPin,
	output logic             rxValid,
	input  wire logic        rxReady,
	output logic      [7:0]  rxData
);
	localparam logic IDLE_LEVEL = NEG_POLARITY;

	csi_state_t state_reg, state_next;
	logic       portSelect_reg, portSelect_next;
	logic       outEnable_reg, outEnable_next;
	logic [3:0] mode_reg, mode_next;
	logic [7:0] shift_reg, shift_next;
	logic [2:0] bitCnt_reg, bitCnt_next;
	logic       sclk_reg, sclk_next;
	logic       outBit_reg, outBit_next;
	logic       sample_reg, sample_next;
	logic       oscHalf_reg, oscHalf_next;
	logic [3:0] rdData_reg, rdData_next;
	logic       selTick;
	logic       fifoInReady;
	logic       fifoPush;
	logic       busy;
	logic       msbFirst;
	logic       phaseLate;
	logic       wrCtrl;

	// ==========================================================
	// Helpers shared by the shift engine and the register address decode
	function automatic logic firstBit(input logic [7:0] d, input logic msb);
		firstBit = msb ? d[7] : d[0];
	endfunction

	function automatic logic [7:0] shiftIn(input logic [7:0] d, input logic msb,
		input logic b);
		shiftIn = msb ? {d[6:0], b} : {b, d[7:1]};
	endfunction

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
		hit = (a == ref_a);
	endfunction

	// ==========================================================
	// Clock source selection
	assign msbFirst  = mode_reg[CSI_MODE_ORDER];
	assign phaseLate = mode_reg[CSI_MODE_PHASE];
	assign busy      = (state_reg != CSI_IDLE);
	assign wrCtrl    = regWrStb && hit(regAddr, CSI_ADDR_CTRL);

	// Four tick sources, the divided one halves the oscillator rate
	always_comb begin
		oscHalf_next = oscHalf_reg ^ lowSpeedOscTick;
		case (mode_reg[CSI_MODE_SRC_HI:CSI_MODE_SRC_LO])
			CSI_SRC_TICK_A:   selTick = timerTickA;
			CSI_SRC_TICK_B:   selTick = timerTickB;
			CSI_SRC_OSC_DIV2: selTick = lowSpeedOscTick && oscHalf_reg;
			CSI_SRC_OSC:      selTick = lowSpeedOscTick;
			default:          selTick = 1'b0;
		endcase
	end

	// ==========================================================
	// Register writes and the transfer sequencer
	always_comb begin
		state_next      = state_reg;
		portSelect_next = portSelect_reg;
		outEnable_next  = outEnable_reg;
		mode_next       = mode_reg;
		shift_next      = shift_reg;
		bitCnt_next     = bitCnt_reg;
		sclk_next       = sclk_reg;
		outBit_next     = outBit_reg;
		sample_next     = sample_reg;
		fifoPush        = 1'b0;
		// Control and mode writes
		if (wrCtrl) begin
			portSelect_next = regWrData[CSI_CTRL_PORT_SEL];
			outEnable_next  = regWrData[CSI_CTRL_OUT_EN];
		end
		if (regWrStb && hit(regAddr, CSI_ADDR_MODE)) begin
			mode_next = regWrData;
		end
		// Data nibble writes
		if (regWrStb && hit(regAddr, CSI_ADDR_DATA_L)) begin
			shift_next[3:0] = regWrData;
		end
		if (regWrStb && hit(regAddr, CSI_ADDR_DATA_H)) begin
			shift_next[7:4] = regWrData;
		end
		case (state_reg)
			CSI_IDLE: begin
				sclk_next = IDLE_LEVEL;
				if (wrCtrl && regWrData[CSI_CTRL_TRIGGER]) begin
					state_next  = CSI_RUN;
					bitCnt_next = '0;
					if (!phaseLate) begin
						outBit_next = firstBit(shift_reg, msbFirst);
					end
				end
			end
			CSI_RUN: begin
				if (selTick) begin
					sclk_next = ~sclk_reg;
					if (sclk_reg == IDLE_LEVEL) begin
						// Leading edge: early phase samples, late phase presents
						if (!phaseLate) begin
							sample_next = serialInputPin;
						end else begin
							outBit_next = firstBit(shift_reg, msbFirst);
						end
					end else begin
						// Trailing edge: the bit is shifted in
						shift_next = shiftIn(shift_reg, msbFirst,
							phaseLate ? serialInputPin : sample_reg);
						if (!phaseLate) begin
							outBit_next = firstBit(shift_next, msbFirst);
						end
						bitCnt_next = bitCnt_reg + 1'b1;
						if (bitCnt_reg == CSI_LAST_BIT) begin
							state_next = CSI_DONE;
						end
					end
				end
			end
			CSI_DONE: begin
				// Status stays running until the byte fits in the FIFO
				if (fifoInReady) begin
					fifoPush   = 1'b1;
					state_next = CSI_IDLE;
				end
			end
			default: begin
				state_next = CSI_IDLE;
			end
		endcase
	end

	// Sequencer and register storage
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg      <= CSI_IDLE;
			portSelect_reg <= CSI_CTRL_RESET[CSI_CTRL_PORT_SEL];
			outEnable_reg  <= CSI_CTRL_RESET[CSI_CTRL_OUT_EN];
			mode_reg       <= CSI_MODE_RESET;
			shift_reg      <= CSI_DATA_RESET;
			bitCnt_reg     <= '0;
			sclk_reg       <= IDLE_LEVEL;
			outBit_reg     <= 1'b0;
			sample_reg     <= 1'b0;
			oscHalf_reg    <= 1'b0;
		end else begin
			state_reg      <= state_next;
			portSelect_reg <= portSelect_next;
			outEnable_reg  <= outEnable_next;
			mode_reg       <= mode_next;
			shift_reg      <= shift_next;
			bitCnt_reg     <= bitCnt_next;
			sclk_reg       <= sclk_next;
			outBit_reg     <= outBit_next;
			sample_reg     <= sample_next;
			oscHalf_reg    <= oscHalf_next;
		end
	end

	// ==========================================================
	// Read port, data valid one cycle after the strobe
	always_comb begin
		rdData_next = 4'h0;
		if (regRdStb) begin
			case (regAddr)
				CSI_ADDR_CTRL:   rdData_next = {1'b0, outEnable_reg, busy,
					portSelect_reg};
				CSI_ADDR_MODE:   rdData_next = mode_reg;
				CSI_ADDR_DATA_L: rdData_next = shift_reg[3:0];
				CSI_ADDR_DATA_H: rdData_next = shift_reg[7:4];
				default:         rdData_next = 4'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_reg <= 4'h0;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	assign regRdData = rdData_reg;

	// ==========================================================
	// Pin function mux
	assign sclkPinOut         = portSelect_reg ? sclk_reg : gpioOut[0];
	assign sclkPinOe          = portSelect_reg ? 1'b1 : gpioOe[0];
	assign serialOutputPinOut = portSelect_reg ? outBit_reg : gpioOut[1];
	assign serialOutputPinOe  = portSelect_reg ? outEnable_reg : gpioOe[1];

	// ==========================================================
	// Received bytes leave through the FIFO
	csi_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.inData   (shift_reg),
		.outValid (rxValid),
		.outReady (rxReady),
		.outData  (rxData)
	);

	// ==========================================================
	// Checks
	logic [4:0] edgeCnt_reg;
	logic       divGap_reg;

	// Serial clock edges seen in the current transfer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			edgeCnt_reg <= '0;
		end else if (state_reg == CSI_IDLE) begin
			edgeCnt_reg <= '0;
		end else if (state_reg == CSI_RUN && selTick) begin
			edgeCnt_reg <= edgeCnt_reg + 1'b1;
		end
	end

	// Set by a divided tick, cleared by an oscillator tick passed over
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			divGap_reg <= 1'b0;
		end else if (mode_reg[CSI_MODE_SRC_HI:CSI_MODE_SRC_LO] != CSI_SRC_OSC_DIV2) begin
			divGap_reg <= 1'b0;
		end else if (selTick) begin
			divGap_reg <= 1'b1;
		end else if (lowSpeedOscTick) begin
			divGap_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_gpio_clock_pin: assert property (
		!portSelect_reg |-> (sclkPinOe == gpioOe[0] && sclkPinOut == gpioOut[0]))
		else $error("clock pin not released to port");
	a_out_disabled: assert property (
		(portSelect_reg && !outEnable_reg) |-> !serialOutputPinOe)
		else $error("serial output driven while disabled");
	a_trigger_start: assert property (
		(wrCtrl && regWrData[CSI_CTRL_TRIGGER] && state_reg == CSI_IDLE)
		|=> (state_reg == CSI_RUN) [*2] or (state_reg == CSI_RUN ##1 1'b1))
		else $error("trigger did not start the clock");
	a_zero_ignored: assert property (
		(wrCtrl && !regWrData[CSI_CTRL_TRIGGER] && state_reg == CSI_IDLE)
		|=> state_reg == CSI_IDLE)
		else $error("writing zero started a transfer");
	a_status_read: assert property (
		(regRdStb && regAddr == CSI_ADDR_CTRL)
		|=> regRdData[CSI_CTRL_TRIGGER] == $past(busy))
		else $error("status bit does not show running clock");
	a_msb_order: assert property (
		(state_reg == CSI_RUN && selTick && phaseLate && msbFirst
		&& sclk_reg == IDLE_LEVEL) |=> outBit_reg == $past(shift_reg[7]))
		else $error("msb first order not kept");
	a_lsb_order: assert property (
		(state_reg == CSI_RUN && selTick && phaseLate && !msbFirst
		&& sclk_reg == IDLE_LEVEL) |=> outBit_reg == $past(shift_reg[0]))
		else $error("lsb first order not kept");
	a_idle_level: assert property (
		(state_reg == CSI_IDLE && $past(state_reg) == CSI_IDLE) |-> sclk_reg == IDLE_LEVEL)
		else $error("serial clock not at idle level");
	a_div2_source: assert property (
		(mode_reg[CSI_MODE_SRC_HI:CSI_MODE_SRC_LO] == CSI_SRC_OSC_DIV2 && selTick)
		|-> (lowSpeedOscTick && !divGap_reg))
		else $error("divided source ticks at full rate");
	a_low_nibble: assert property (
		(regWrStb && regAddr == CSI_ADDR_DATA_L && state_reg == CSI_IDLE)
		|=> shift_reg[3:0] == $past(regWrData))
		else $error("low nibble write lost");
	a_high_nibble: assert property (
		(regWrStb && regAddr == CSI_ADDR_DATA_H && state_reg == CSI_IDLE)
		|=> shift_reg[7:4] == $past(regWrData))
		else $error("high nibble write lost");
	a_eight_bits: assert property (
		(state_reg == CSI_DONE && $past(state_reg) == CSI_RUN)
		|-> edgeCnt_reg == CSI_EDGES_XFER)
		else $error("transfer did not take eight clock cycles");
endmodule // csi_serial

// [sim/csi_peer_model.sv]
// Behavioural model of the external serial peripheral on the port pins
`timescale 1ns/1ps
module csi_peer_model #(
	parameter bit IDLE_HIGH = 1'b1
) (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       sclk,
	input  wire logic       sdo,
	input  wire logic       msbFirst,
	input  wire logic       phase,
	input  wire logic [7:0] txByte,
	output logic            sdi,
	output logic      [7:0] rxByte
);
	logic       sclkQ;
	logic [2:0] idx;
	logic       lead;
	logic       trail;
	// ==========================================================
	// Clock edges, seen one core cycle late
	assign lead  = (sclkQ == IDLE_HIGH) && (sclk != IDLE_HIGH);
	assign trail = (sclkQ != IDLE_HIGH) && (sclk == IDLE_HIGH);
	// Each bit shown from one trailing edge to the next
	assign sdi = txByte[msbFirst ? 3'h7 - idx : idx];
	// Sample on the edge the phase picks, step index on trailing edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclkQ  <= IDLE_HIGH;
			idx    <= 3'h0;
			rxByte <= 8'h00;
		end else begin
			sclkQ <= sclk;
			if (phase ? trail : lead) begin
				rxByte <= msbFirst ? {rxByte[6:0], sdo} : {sdo, rxByte[7:1]};
			end
			if (trail) begin
				idx <= idx + 3'h1;
			end
		end
	end
endmodule // csi_peer_model

// [sim/testbench.sv]
// Self-checking bench for the clocked serial interface
`timescale 1ns/1ps
module testbench;
	import csi_pkg::*;
	logic        core_clk  = 1'b0;
	logic        arst_n    = 1'b0;
	logic [15:0] regAddr   = 16'h0000;
	logic [3:0]  regWrData = 4'h0;
	logic        regWrStb  = 1'b0;
	logic        regRdStb  = 1'b0;
	logic [3:0]  regRdData;
	logic        oscTick   = 1'b0;
	logic        tickA     = 1'b0;
	logic        tickB     = 1'b0;
	logic [1:0]  gpioOut   = 2'h1;
	logic [1:0]  gpioOe    = 2'h2;
	logic        sclkOut, sclkOe, sdoOut, sdoOe, sdi, rxValid;
	logic        rxReady   = 1'b0;
	logic        msbFirst  = 1'b0;
	logic        phase     = 1'b0;
	logic [7:0]  rxData, peerRx;
	logic [7:0]  peerTx    = 8'h00;
	int          fail_count = 0;
	int          tests_run  = 0;
	int          cyc        = 0;
	// ==========================================================
	// Clock, tick sources and run ceiling
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc     <= cyc + 1;
		tickA   <= (cyc % 4 == 0);
		tickB   <= (cyc % 6 == 0);
		oscTick <= (cyc % 5 == 0);
		if (cyc == 30000) begin
			fail_count++;
			finish_test();
		end
	end
	csi_serial u_csi_serial (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .lowSpeedOscTick(oscTick), .timerTickA(tickA),
		.timerTickB(tickB), .gpioOut(gpioOut), .gpioOe(gpioOe), .sclkPinOut(sclkOut),
		.sclkPinOe(sclkOe), .serialOutputPinOut(sdoOut), .serialOutputPinOe(sdoOe),
		.serialInputPin(sdi), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData));
	// Released pins rest at the pull-up level
	csi_peer_model u_csi_peer_model (.core_clk(core_clk), .arst_n(arst_n),
		.sclk(sclkOe ? sclkOut : 1'b1), .sdo(sdoOe ? sdoOut : 1'b1), .msbFirst(msbFirst),
		.phase(phase), .txByte(peerTx), .sdi(sdi), .rxByte(peerRx));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWrStb  <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [15:0] a, output logic [3:0] d);
		regAddr  <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1 d = regRdData;
		@(posedge core_clk);
	endtask
	task automatic rdChk(input logic [15:0] a, input logic [3:0] e);
		logic [3:0] d;
		rd(a, d);
		chk({4'h0, d}, {4'h0, e});
	endtask
	task automatic pins(input logic [7:0] e);
		#1 chk({5'h0, sclkOut, sclkOe, sdoOe}, e);
		@(posedge core_clk);
	endtask
	task automatic pop(input logic [7:0] e);
		#1 chk({7'h0, rxValid}, 8'h01);
		chk(rxData, e);
		@(posedge core_clk);
		rxReady <= 1'b1;
		@(posedge core_clk);
		rxReady <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic xfer(input logic [3:0] m, input logic [7:0] dv, input logic [7:0] pr,
		input bit take, input int per);
		logic [3:0] d;
		int n;
		msbFirst <= m[CSI_MODE_ORDER];
		phase    <= m[CSI_MODE_PHASE];
		peerTx   <= pr;
		wr(CSI_ADDR_MODE, m);
		wr(CSI_ADDR_DATA_L, dv[3:0]);
		wr(CSI_ADDR_DATA_H, dv[7:4]);
		wr(CSI_ADDR_CTRL, 4'h7);
		rdChk(CSI_ADDR_CTRL, 4'h7);
		n = 0;
		d = 4'h7;
		while (d[CSI_CTRL_TRIGGER] === 1'b1 && n < 400) begin
			rd(CSI_ADDR_CTRL, d);
			n++;
		end
		chk({4'h0, d}, 8'h05);
		chk({7'h0, 2 * n + 2 >= 15 * per && 2 * n + 2 <= 16 * per + 10}, 8'h01);
		chk(peerRx, dv);
		rdChk(CSI_ADDR_DATA_L, pr[3:0]);
		rdChk(CSI_ADDR_DATA_H, pr[7:4]);
		pins(8'h07);
		if (take) begin
			pop(pr);
		end
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		pins(8'h05);
		rdChk(CSI_ADDR_CTRL, CSI_CTRL_RESET);
		rdChk(CSI_ADDR_MODE, CSI_MODE_RESET);
		rdChk(CSI_ADDR_DATA_L, 4'h0);
		rdChk(CSI_ADDR_DATA_H, 4'h0);
		rdChk(16'hFF74, 4'h0);
	endtask
	task automatic t_pins();
		wr(CSI_ADDR_CTRL, 4'h1);
		pins(8'h06);
		wr(CSI_ADDR_CTRL, 4'h5);
		pins(8'h07);
		rdChk(CSI_ADDR_CTRL, 4'h5);
		wr(CSI_ADDR_DATA_L, 4'hA);
		wr(CSI_ADDR_DATA_H, 4'h5);
		wr(16'hFF74, 4'hF);
		rdChk(CSI_ADDR_DATA_L, 4'hA);
		rdChk(CSI_ADDR_DATA_H, 4'h5);
	endtask
	task automatic t_modes();
		int per[4] = '{4, 6, 10, 5};
		for (int i = 0; i < 4; i++) begin
			xfer({i[1], i[0], i[1:0]}, 8'hB1 + i[7:0], 8'h4E + i[7:0], 1'b1, per[i]);
		end
	endtask
	task automatic t_fifo();
		for (int k = 0; k < 8; k++) begin
			xfer(4'h8, 8'hC3, 8'h10 + k[7:0], 1'b0, 4);
		end
		peerTx <= 8'h18;
		wr(CSI_ADDR_CTRL, 4'h7);
		repeat (200) @(posedge core_clk);
		rdChk(CSI_ADDR_CTRL, 4'h7);
		for (int k = 0; k < 9; k++) begin
			pop(8'h10 + k[7:0]);
		end
		rdChk(CSI_ADDR_CTRL, 4'h5);
		#1 chk({7'h0, rxValid}, 8'h00);
		@(posedge core_clk);
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_pins();
		t_modes();
		t_fifo();
		finish_test();
	end
endmodule // testbench
